// ### rtl/isb_bridge_core.v
// isb_bridge_core.v: two-wire slave to SPI master bridge engine.
// Assumes open-drain pads outside; pins arrive unsynchronised.
//
// Overview of operation
// - Slave only, byte oriented, up to 400 kHz
// - May stretch clock low between bytes
// - Address byte: seven bits plus direction bit
// - Address low three bits from select pins
// - Select pins captured at reset only
// - Active-low reset returns initial state
// - No address acknowledge while busy
// - Write: address, function, up to 200 bytes
// - Data bytes stored in order until STOP
// - After STOP, silent until function done
// - Function 01h to 0Fh starts SPI transfer
// - Function bits drive matching active-low selects
// - SPI sends only the data bytes
// - Sends exactly as many bytes as received
// - MISO bytes overwrite same buffer position
// - Addressed read returns buffer from start
// - Buffer read leaves contents unchanged
// - Device is SPI master, up to 1.8 Mbit/s
// - Interrupt low on completion, F1h clears
// - F0h byte sets order, mode, rate
// - Selects act as SPI selects after reset
`include "isb_defs.vh"

module isb_bridge_core (
   input  wire clk_sys_i,
   input  wire rst_n_i,
   input  wire scl_i,
   output wire scl_o,
   output wire scl_oe_o,
   input  wire sda_i,
   output wire sda_o,
   output reg  sda_oe_o,
   input  wire addr_sel_pin_0_i,
   input  wire addr_sel_pin_1_i,
   input  wire addr_sel_pin_2_i,
   input  wire miso_i,
   output wire mosi_o,
   output wire serial_clk_out_o,
   output wire slave_select_0_n_o,
   output wire slave_select_1_n_o,
   output wire slave_select_2_n_o,
   output wire slave_select_3_n_o,
   output wire int_n_o
);
   // Two-wire slave states
   localparam S_IDLE = 3'd0;
   localparam S_ADDR = 3'd1;
   localparam S_AACK = 3'd2;
   localparam S_RX   = 3'd3;
   localparam S_RACK = 3'd4;
   localparam S_LOAD = 3'd5;
   localparam S_TX   = 3'd6;
   localparam S_TACK = 3'd7;

   // Pin synchronisers and edge history
   reg [1:0] scl_sy;
   reg [1:0] sda_sy;
   reg       scl_d;
   reg       sda_d;
   reg [2:0] addr_sy1;
   reg [2:0] addr_sy2;
   reg [2:0] addr_lat;

   // Slave state
   reg [2:0] st;
   reg [3:0] bitcnt;
   reg [7:0] shreg;
   reg       rw;
   reg       tx_ack;
   reg       got_func;
   reg [7:0] func;
   reg [7:0] wr_cnt;
   reg [7:0] rd_ptr;
   reg [7:0] cfg_byte;
   reg [7:0] cfg;

   // Execution state
   reg       spi_go;
   reg [3:0] spi_sel;
   reg [7:0] spi_cnt;
   reg       irq;

   // Shared data buffer
   reg [7:0] mem [0:199];

   wire       spi_busy;
   wire       spi_done;
   wire       spi_we;
   wire [7:0] spi_idx;
   wire [7:0] spi_rx;
   wire [3:0] ss_n;

   // Bus line views after synchronisation
   wire scl_s = scl_sy[1];
   wire sda_s = sda_sy[1];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   // Data edges while clock high mark START and STOP
   wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
   wire byte_end = scl_fall & (bitcnt == `ISB_BITS);

   // Busy covers the cycle the SPI start is still in flight
   wire busy = spi_busy | spi_go;

   // Own address: fixed part plus latched pins
   wire [6:0] own_addr = {`ISB_ADDR_HI, addr_lat};
   wire       addr_hit = (shreg[7:1] == own_addr);

   // Function decode used at STOP
   wire fn_spi = (func != 8'h00) &&
                 (func <= `ISB_FN_SPI_MAX);
   wire fn_cfg = (func == `ISB_FN_CFG);
   wire fn_clr = (func == `ISB_FN_CLR);
   wire msg_done = bus_stop & got_func;

   // A data byte is stored only after the function byte
   wire i2c_we = (st == S_RX) & byte_end & got_func &
                 (wr_cnt < `ISB_BUF_DEPTH);

   // Buffer read ports, one per side
   wire [7:0] rd_byte = mem[rd_ptr];
   wire [7:0] spi_tx = mem[spi_idx];

   // Open-drain pins: output level is always low
   assign sda_o = 1'b0;
   assign scl_o = 1'b0;
   // Clock held low only while fetching the next byte
   assign scl_oe_o = (st == S_LOAD);

   // Selects stay SPI selects; no GPIO use here
   assign slave_select_0_n_o = ss_n[0];
   assign slave_select_1_n_o = ss_n[1];
   assign slave_select_2_n_o = ss_n[2];
   assign slave_select_3_n_o = ss_n[3];
   assign int_n_o = ~irq;

   // Two flops before any logic sees a pin
   // No reset here so pin levels flow even while reset is held
   always @(posedge clk_sys_i) begin
      scl_sy <= {scl_sy[0], scl_i};
      sda_sy <= {sda_sy[0], sda_i};
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
      addr_sy1 <= {addr_sel_pin_2_i, addr_sel_pin_1_i,
                   addr_sel_pin_0_i};
      addr_sy2 <= addr_sy1;
   end

   // Address pins tracked during reset, frozen after
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         addr_lat <= addr_sy2;
      end
   end

   // Buffer writes; SPI never overlaps a bus write
   // because the address is refused while busy
   always @(posedge clk_sys_i) begin
      if (spi_we) begin
         mem[spi_idx] <= spi_rx;
      end else if (i2c_we) begin
         mem[wr_cnt] <= shreg;
      end
   end

   // Two-wire slave; never drives START or a clock
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st <= S_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         rw <= 1'b0;
         tx_ack <= 1'b0;
         got_func <= 1'b0;
         func <= 8'h00;
         wr_cnt <= 8'h00;
         rd_ptr <= 8'h00;
         cfg_byte <= 8'h00;
         sda_oe_o <= 1'b0;
      end else if (bus_start) begin
         // Repeated START abandons an unfinished write
         st <= S_ADDR;
         bitcnt <= 4'h0;
         got_func <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
         // Function runs from here; see execution block
         st <= S_IDLE;
         got_func <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         case (st)
            S_IDLE: begin
               sda_oe_o <= 1'b0;
            end
            S_ADDR, S_RX: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_end && st == S_ADDR) begin
                  if (addr_hit && !busy) begin
                     sda_oe_o <= 1'b1;
                     rw <= shreg[0];
                     st <= S_AACK;
                  end else begin
                     st <= S_IDLE;
                  end
               end else if (byte_end) begin
                  if (!got_func) begin
                     func <= shreg;
                     got_func <= 1'b1;
                     sda_oe_o <= 1'b1;
                     st <= S_RACK;
                  end else if (i2c_we) begin
                     if (wr_cnt == 8'h00) begin
                        cfg_byte <= shreg;
                     end
                     wr_cnt <= wr_cnt + 8'h01;
                     sda_oe_o <= 1'b1;
                     st <= S_RACK;
                  end else begin
                     // Buffer full: byte refused by NACK
                     st <= S_IDLE;
                  end
               end
            end
            S_AACK: begin
               if (scl_fall) begin
                  sda_oe_o <= 1'b0;
                  bitcnt <= 4'h0;
                  if (rw) begin
                     rd_ptr <= 8'h00;
                     st <= S_LOAD;
                  end else begin
                     wr_cnt <= 8'h00;
                     st <= S_RX;
                  end
               end
            end
            S_RACK: begin
               if (scl_fall) begin
                  sda_oe_o <= 1'b0;
                  bitcnt <= 4'h0;
                  st <= S_RX;
               end
            end
            S_LOAD: begin
               // Read only; the buffer is left as it was
               shreg <= rd_byte;
               sda_oe_o <= ~rd_byte[7];
               rd_ptr <= (rd_ptr == `ISB_BUF_LAST) ? 8'h00 :
                         rd_ptr + 8'h01;
               bitcnt <= 4'h1;
               st <= S_TX;
            end
            S_TX: begin
               if (scl_fall) begin
                  if (bitcnt == `ISB_BITS) begin
                     sda_oe_o <= 1'b0;
                     st <= S_TACK;
                  end else begin
                     shreg <= {shreg[6:0], 1'b0};
                     sda_oe_o <= ~shreg[6];
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
            end
            S_TACK: begin
               // A NACK ends the read; STOP follows
               if (scl_rise) begin
                  tx_ack <= ~sda_s;
               end else if (scl_fall) begin
                  st <= tx_ack ? S_LOAD : S_IDLE;
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end

   // Function execution at the end of a write message
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         spi_go <= 1'b0;
         spi_sel <= 4'h0;
         spi_cnt <= 8'h00;
         cfg <= `ISB_CFG_RST;
      end else begin
         spi_go <= 1'b0;
         if (msg_done && fn_spi) begin
            spi_go <= 1'b1;
            spi_sel <= func[3:0];
            spi_cnt <= wr_cnt;
         end else if (msg_done && fn_cfg &&
                      wr_cnt != 8'h00) begin
            cfg <= cfg_byte;
         end
      end
   end

   // Interrupt: completion sets, clear function resets;
   // a completion in the clear cycle wins
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         irq <= 1'b0;
      end else if (spi_done) begin
         irq <= 1'b1;
      end else if (msg_done && fn_clr) begin
         irq <= 1'b0;
      end
   end

   // SPI master; contention with several selects is the
   // host's concern, not checked here
   isb_spi_master u_spi (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .start_i     (spi_go),
      .count_i     (spi_cnt),
      .sel_i       (spi_sel),
      .lsb_first_i (cfg[`ISB_CFG_ORDER]),
      .cpol_i      (cfg[`ISB_CFG_CPOL]),
      .cpha_i      (cfg[`ISB_CFG_CPHA]),
      .rate_i      (cfg[`ISB_CFG_RATE_HI:`ISB_CFG_RATE_LO]),
      .miso_i      (miso_i),
      .tx_data_i   (spi_tx),
      .idx_o       (spi_idx),
      .rx_data_o   (spi_rx),
      .rx_we_o     (spi_we),
      .busy_o      (spi_busy),
      .done_o      (spi_done),
      .sclk_o      (serial_clk_out_o),
      .mosi_o      (mosi_o),
      .ss_n_o      (ss_n)
   );
endmodule

// ### rtl/isb_defs.vh
// isb_defs.vh: shared constants of the two-wire to SPI bridge.
// Assumes inclusion by the rtl files of this block only.
`ifndef ISB_DEFS_VH
`define ISB_DEFS_VH
// System clock rate in kHz
`define ISB_CLK_KHZ 25000
// Fixed upper part of the bus address, arbitrary value
`define ISB_ADDR_HI 4'h5
// Buffer size and last index
`define ISB_BUF_DEPTH 8'd200
`define ISB_BUF_LAST 8'd199
// Bits per byte on both buses
`define ISB_BITS 4'h8
// Function identifiers
`define ISB_FN_SPI_MAX 8'h0f
`define ISB_FN_CFG 8'hf0
`define ISB_FN_CLR 8'hf1
// Configuration byte reset value and field positions
`define ISB_CFG_RST 8'h00
`define ISB_CFG_ORDER 5
`define ISB_CFG_CPOL 3
`define ISB_CFG_CPHA 2
`define ISB_CFG_RATE_HI 1
`define ISB_CFG_RATE_LO 0
// SPI clock rates in kHz
`define ISB_RATE0_KHZ 1843
`define ISB_RATE1_KHZ 461
`define ISB_RATE2_KHZ 115
`define ISB_RATE3_KHZ 58
// Half period in cycles, rounded up so a rate is never exceeded
`define ISB_HALF(k) ((`ISB_CLK_KHZ + 2 * (k) - 1) / (2 * (k)))
// Last of the sixteen clock edges of one SPI byte
`define ISB_EDGE_LAST 4'hf
`endif

// ### rtl/isb_spi_master.v
// isb_spi_master.v: SPI master shifter for the bridge buffer.
// Assumes the caller serves tx_data_i from buffer[idx_o] without delay.
`include "isb_defs.vh"

module isb_spi_master (
   input  wire       clk_sys_i,
   input  wire       rst_n_i,
   input  wire       start_i,
   input  wire [7:0] count_i,
   input  wire [3:0] sel_i,
   input  wire       lsb_first_i,
   input  wire       cpol_i,
   input  wire       cpha_i,
   input  wire [1:0] rate_i,
   input  wire       miso_i,
   input  wire [7:0] tx_data_i,
   output reg  [7:0] idx_o,
   output reg  [7:0] rx_data_o,
   output reg        rx_we_o,
   output wire       busy_o,
   output reg        done_o,
   output reg        sclk_o,
   output reg        mosi_o,
   output reg  [3:0] ss_n_o
);
   localparam SP_IDLE  = 3'd0;
   localparam SP_LOAD  = 3'd1;
   localparam SP_SHIFT = 3'd2;
   localparam SP_NEXT  = 3'd3;
   localparam SP_HOLD  = 3'd4;
   localparam [31:0] H0 = `ISB_HALF(`ISB_RATE0_KHZ);
   localparam [31:0] H1 = `ISB_HALF(`ISB_RATE1_KHZ);
   localparam [31:0] H2 = `ISB_HALF(`ISB_RATE2_KHZ);
   localparam [31:0] H3 = `ISB_HALF(`ISB_RATE3_KHZ);

   reg [2:0] st;
   reg [7:0] half;
   reg [7:0] hc;
   reg [3:0] ec;
   reg [2:0] obit;
   reg [7:0] tx;
   reg [7:0] rx_sh;
   reg [7:0] cnt;
   reg       lsb;
   reg       cpha;
   reg [1:0] miso_sy;

   // Half period in cycles for a rate code
   function [7:0] half_cnt;
      input [1:0] r;
      begin
         case (r)
            2'd0:    half_cnt = H0[7:0];
            2'd1:    half_cnt = H1[7:0];
            2'd2:    half_cnt = H2[7:0];
            default: half_cnt = H3[7:0];
         endcase
      end
   endfunction

   // Bit n of a byte in the chosen order
   function bit_at;
      input [7:0] b;
      input [2:0] n;
      input       l;
      begin
         bit_at = l ? b[n] : b[3'd7 - n];
      end
   endfunction

   wire       tick = (hc == half - 8'h01);
   wire [7:0] samp = lsb ? {miso_sy[1], rx_sh[7:1]}
                         : {rx_sh[6:0], miso_sy[1]};
   assign busy_o = (st != SP_IDLE);

   // MISO is a pin, so two flops before use
   always @(posedge clk_sys_i) begin
      miso_sy <= {miso_sy[0], miso_i};
   end

   // Sequencer: selects, sixteen edges a byte, then hold
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st <= SP_IDLE;
         half <= 8'h01;
         hc <= 8'h00;
         ec <= 4'h0;
         obit <= 3'h0;
         tx <= 8'h00;
         rx_sh <= 8'h00;
         cnt <= 8'h00;
         lsb <= 1'b0;
         cpha <= 1'b0;
         idx_o <= 8'h00;
         rx_data_o <= 8'h00;
         rx_we_o <= 1'b0;
         done_o <= 1'b0;
         sclk_o <= 1'b0;
         mosi_o <= 1'b0;
         ss_n_o <= 4'hf;
      end else begin
         done_o <= 1'b0;
         rx_we_o <= 1'b0;
         case (st)
            SP_IDLE: begin
               sclk_o <= cpol_i; // Idle level follows polarity
               if (start_i) begin
                  lsb <= lsb_first_i;
                  cpha <= cpha_i;
                  half <= half_cnt(rate_i);
                  cnt <= count_i;
                  idx_o <= 8'h00;
                  hc <= 8'h00;
                  if (count_i == 8'h00) begin
                     done_o <= 1'b1;
                  end else begin
                     ss_n_o <= ~sel_i;
                     st <= SP_LOAD;
                  end
               end
            end
            SP_LOAD: begin
               tx <= tx_data_i;
               ec <= 4'h0;
               hc <= 8'h00;
               rx_sh <= 8'h00;
               if (!cpha) begin
                  mosi_o <= bit_at(tx_data_i, 3'h0, lsb);
                  obit <= 3'h1;
               end else begin
                  obit <= 3'h0;
               end
               st <= SP_SHIFT;
            end
            SP_SHIFT: begin
               if (tick) begin
                  hc <= 8'h00;
                  sclk_o <= ~sclk_o;
                  ec <= ec + 4'h1;
                  if (ec[0] == cpha) begin
                     rx_sh <= samp;
                  end else if (ec != `ISB_EDGE_LAST) begin
                     mosi_o <= bit_at(tx, obit, lsb);
                     obit <= obit + 3'h1;
                  end
                  if (ec == `ISB_EDGE_LAST) begin
                     // Received byte replaces the sent one
                     rx_data_o <= cpha ? samp : rx_sh;
                     rx_we_o <= 1'b1;
                     st <= (idx_o == cnt - 8'h01) ? SP_HOLD : SP_NEXT;
                  end
               end else begin
                  hc <= hc + 8'h01;
               end
            end
            SP_NEXT: begin
               // Index moves after the write has used it
               idx_o <= idx_o + 8'h01;
               st <= SP_LOAD;
            end
            SP_HOLD: begin
               if (tick) begin
                  ss_n_o <= 4'hf;
                  done_o <= 1'b1;
                  st <= SP_IDLE;
               end else begin
                  hc <= hc + 8'h01;
               end
            end
            default: st <= SP_IDLE;
         endcase
      end
   end
endmodule

// ### tb/isb_bridge_core_bench.sv
// isb_bridge_core_bench.sv: self-checking bench for the bridge engine.
// Assumes pull-ups on both bus lines and one mode 0 SPI slave.
`include "isb_defs.vh"

module isb_bridge_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] DEV   = {`ISB_ADDR_HI, 3'b101};
   localparam int         LIMIT = 60000; // Run needs about 30000 cycles
   logic       clk_sys_i = 1'b0;
   logic       rst_n_i   = 1'b0;
   logic       miso      = 1'b0;
   logic [2:0] apin      = 3'b101;
   wire        scl_oe, sda_oe, h_scl, h_sda, mosi, sclk, int_n;
   wire        scl_lo, sda_lo;
   wire  [3:0] slave_select_n;
   // Pads pull the line only when enabled and driving a low level
   wire        scl = ~((scl_oe & ~scl_lo) | h_scl);
   wire        sda = ~((sda_oe & ~sda_lo) | h_sda);
   int         n_errors = 0;
   int         num_checks = 0;
   int         cyc = 0;
   int         frames = 0;
   int         s_bit = 0;
   logic [3:0] s_sel;
   logic [7:0] s_sh;
   logic [7:0] s_tx[$];
   logic [7:0] s_rx[$];
   logic [7:0] q[$];

   always #20 clk_sys_i = ~clk_sys_i;

   isb_bridge_core i_dut (
      .clk_sys_i (clk_sys_i), .rst_n_i (rst_n_i),
      .scl_i (scl), .scl_o (scl_lo), .scl_oe_o (scl_oe),
      .sda_i (sda), .sda_o (sda_lo), .sda_oe_o (sda_oe),
      .addr_sel_pin_0_i (apin[0]), .addr_sel_pin_1_i (apin[1]),
      .addr_sel_pin_2_i (apin[2]), .miso_i (miso), .mosi_o (mosi),
      .serial_clk_out_o (sclk),
      .slave_select_0_n_o (slave_select_n[0]), .slave_select_1_n_o (slave_select_n[1]),
      .slave_select_2_n_o (slave_select_n[2]), .slave_select_3_n_o (slave_select_n[3]),
      .int_n_o (int_n));
   isb_host_model i_host (.scl_i (scl), .sda_i (sda),
      .scl_oe_o (h_scl), .sda_oe_o (h_sda));

   // One slave answers any mix of selects, so MISO never fights
   always @(negedge (&slave_select_n)) begin
      frames++;
      s_bit = 0;
      miso = s_tx.size() ? s_tx[0][7] : 1'b0;
   end
   // A released MISO line shows the inverse of its last bit
   always @(posedge (&slave_select_n)) miso = ~miso;
   // Mode 0: capture on the rising edge, next bit on the falling one
   always @(posedge sclk) if (!(&slave_select_n)) begin
      s_sel = slave_select_n;
      s_sh = {s_sh[6:0], mosi};
      s_bit++;
      if (s_bit == 8) begin
         s_rx.push_back(s_sh);
         if (s_tx.size()) void'(s_tx.pop_front());
         s_bit = 0;
      end
   end
   always @(negedge sclk) if (!(&slave_select_n) && s_tx.size()) miso = s_tx[0][7 - s_bit];

   task automatic tally_and_finish();
      if (n_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Cuts a hung run short
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_errors++;
         $display("[ERR] %0t run timed out", $time);
         tally_and_finish();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmpq(input logic [7:0] got[$], input logic [7:0] exp[$]);
      chk(8'(got.size()), 8'(exp.size()));
      foreach (exp[i]) chk(got[i], exp[i]);
   endtask
   // Write message; n_ok counts acknowledged bytes, address included
   task automatic send(input logic [6:0] a, input logic [7:0] d[$],
                       output int n_ok);
      logic k;
      i_host.start();
      i_host.wbyte({a, 1'b0}, k);
      n_ok = int'(k);
      foreach (d[i]) if (k) begin
         i_host.wbyte(d[i], k);
         n_ok += int'(k);
      end
      i_host.stop();
   endtask
   // Buffer read of n bytes from the start
   task automatic fetch(input int n, output logic [7:0] r[$]);
      logic       k;
      logic [7:0] b;
      r = {};
      i_host.start();
      i_host.wbyte({DEV, 1'b1}, k);
      chk({7'h0, k}, 8'h01);
      for (int i = 0; i < n; i++) begin
         i_host.rbyte(b, i == n - 1);
         r.push_back(b);
      end
      i_host.stop();
   endtask
   // Bounded wait for the interrupt line to reach a level
   task automatic wait_int(input logic lvl);
      for (int i = 0; i < 3000 && int_n !== lvl; i++) @(posedge clk_sys_i);
      #5;
   endtask

   task automatic t_addr();
      int n;
      apin = 3'b010;
      send({`ISB_ADDR_HI, 3'b010}, {8'h00}, n);
      chk(8'(n), 8'd0);
      send(DEV, {8'h00}, n);
      chk(8'(n), 8'd2);
   endtask
   // Byte 201 refused; stored bytes keep their order
   task automatic t_full();
      int         n;
      logic [7:0] d[$];
      d = {8'h00};
      for (int i = 0; i < 201; i++) d.push_back(8'(i));
      send(DEV, d, n);
      chk(8'(n), 8'd202);
      fetch(2, q);
      cmpq(q, {8'h00, 8'h01});
   endtask
   task automatic t_spi();
      int n;
      s_tx = {8'h5a, 8'hc3, 8'h7e};
      s_rx = {};
      send(DEV, {8'h05, 8'ha5, 8'h3c, 8'h81}, n);
      chk(8'(n), 8'd5);
      send(DEV, {8'h00}, n);
      chk(8'(n), 8'd0);
      wait_int(1'b0);
      chk({~int_n, 3'h0, s_sel}, 8'h8a);
      cmpq(s_rx, {8'ha5, 8'h3c, 8'h81});
      fetch(3, q);
      cmpq(q, {8'h5a, 8'hc3, 8'h7e});
      fetch(3, q);
      cmpq(q, {8'h5a, 8'hc3, 8'h7e});
      send(DEV, {8'hf1}, n);
      wait_int(1'b1);
      chk({7'h0, int_n}, 8'h01);
   endtask
   // Every select pattern, one byte each, interrupt cleared between
   task automatic t_ids();
      int n;
      for (int id = 1; id < 16; id++) begin
         s_tx = {8'h3c};
         send(DEV, {8'(id), 8'hc3}, n);
         chk(8'(n), 8'd3);
         wait_int(1'b0);
         chk({4'h0, s_sel}, {4'h0, ~4'(id)});
         send(DEV, {8'hf1}, n);
         wait_int(1'b1);
      end
   endtask
   // Identifier above 0Fh and an empty transfer send nothing
   task automatic t_zero();
      int n;
      int f;
      f = frames;
      send(DEV, {8'h10, 8'h3c}, n);
      chk(8'(n), 8'd3);
      send(DEV, {8'h0f}, n);
      wait_int(1'b0);
      chk({7'h0, int_n}, 8'h00);
      chk(8'(frames - f), 8'd0);
   endtask
   // LSB first at the second rate; bytes come back bit-reversed
   task automatic t_cfg();
      int n;
      s_tx = {8'h03};
      s_rx = {};
      send(DEV, {8'hf1}, n);
      send(DEV, {8'hf0, 8'h21}, n);
      chk(8'(n), 8'd3);
      send(DEV, {8'h01, 8'h01}, n);
      wait_int(1'b0);
      cmpq(s_rx, {8'h80});
      fetch(1, q);
      cmpq(q, {8'hc0});
   endtask
   // Second reset in mid-run takes the new pin levels
   task automatic t_rereset();
      int n;
      apin = 3'b011;
      rst_n_i = 1'b0;
      repeat (6) @(posedge clk_sys_i);
      #5 rst_n_i = 1'b1;
      chk({1'b0, scl_oe, sda_oe, int_n, slave_select_n}, 8'h1f);
      send({`ISB_ADDR_HI, 3'b011}, {8'h01, 8'h01}, n);
      chk(8'(n), 8'd3);
      wait_int(1'b0);
      chk(s_rx[$], 8'h01);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys_i);
      #5 rst_n_i = 1'b1;
      chk({1'b0, scl_oe, sda_oe, int_n, slave_select_n}, 8'h1f);
      t_addr();
      t_full();
      t_spi();
      t_ids();
      t_zero();
      t_cfg();
      t_rereset();
      tally_and_finish();
   end
endmodule

// ### tb/isb_bridge_core_props.sv
// isb_bridge_core_props.sv: port checker for the bridge engine.
// Assumes one clock domain and the SPI mode that reset selects.
module isb_bridge_core_props (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire scl_i,
   input wire scl_oe_o,
   input wire sda_oe_o,
   input wire serial_clk_out_o,
   input wire slave_select_0_n_o,
   input wire slave_select_1_n_o,
   input wire slave_select_2_n_o,
   input wire slave_select_3_n_o,
   input wire int_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire  [3:0] sel_n = {slave_select_3_n_o, slave_select_2_n_o,
                        slave_select_1_n_o, slave_select_0_n_o};
   wire        idle  = &sel_n;
   logic [3:0] n_edges;
   // Serial clock edges in a frame; whole bytes leave the count at 0
   always @(posedge clk_sys_i)
      if (!rst_n_i || idle)
         n_edges <= 4'h0;
      else if ($changed(serial_clk_out_o))
         n_edges <= n_edges + 4'h1;
   sequence s_frame_end;
      $rose(idle);
   endsequence
   sequence s_stretch;
      $rose(scl_oe_o);
   endsequence
   a_reset_quiet:
   assert property (disable iff (1'b0)
      !rst_n_i |=> !scl_oe_o && !sda_oe_o && idle && int_n_o)
      else $error("outputs not at rest after reset");
   a_stretch_low:
   assert property (s_stretch |-> !scl_i && !$past(scl_i))
      else $error("clock held while the line was high");
   a_stretch_one:
   assert property (s_stretch |=> !scl_oe_o [*3])
      else $error("clock stretch longer than one cycle");
   a_sel_steady:
   assert property (!idle |=> idle || $stable(sel_n))
      else $error("selects changed inside a frame");
   a_int_after:
   assert property (s_frame_end |-> ##[1:2] !int_n_o)
      else $error("no interrupt after a transfer");
   a_quiet_busy:
   assert property (!idle |-> !sda_oe_o && !scl_oe_o)
      else $error("bus answered during a transfer");
   a_whole_bytes:
   assert property (s_frame_end |-> n_edges == 4'h0)
      else $error("frame ended inside a byte");
   a_half_period:
   assert property ($changed(serial_clk_out_o) |=>
      $stable(serial_clk_out_o) [*6])
      else $error("serial clock faster than allowed");
endmodule

bind isb_bridge_core isb_bridge_core_props i_props (
   .clk_sys_i, .rst_n_i, .scl_i, .scl_oe_o, .sda_oe_o, .serial_clk_out_o,
   .slave_select_0_n_o, .slave_select_1_n_o, .slave_select_2_n_o,
   .slave_select_3_n_o, .int_n_o
);

// ### tb/isb_host_model.sv
// isb_host_model.sv: two-wire bus master standing in for the host.
// Assumes pull-ups; the bench resolves the line levels.
module isb_host_model (
   input  wire  scl_i,
   input  wire  sda_i,
   output logic scl_oe_o,
   output logic sda_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int QTR = 80; // Quarter of the 320 ns bit period
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   // One bit; waits out a stretch, samples late in the high phase
   task automatic bit_io(input logic b, output logic s);
      sda_oe_o = ~b;
      #QTR scl_oe_o = 1'b0;
      for (int i = 0; i < 64 && scl_i !== 1'b1; i++) #10;
      #(2 * QTR) s = sda_i;
      scl_oe_o = 1'b1;
      #QTR;
   endtask
   // Start from idle lines; data falls while the clock is high
   task automatic start();
      #QTR sda_oe_o = 1'b1;
      #(2 * QTR) scl_oe_o = 1'b1;
      #QTR;
   endtask
   // Stop: data rises while the clock is high
   task automatic stop();
      sda_oe_o = 1'b1;
      #QTR scl_oe_o = 1'b0;
      #(2 * QTR) sda_oe_o = 1'b0;
      #(4 * QTR);
   endtask
   // Byte out, most significant bit first, then the slave's answer
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   // Every byte but the last of a read is acknowledged
   task automatic rbyte(output logic [7:0] b, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(last, s);
   endtask
endmodule
